// ---- rtl/aqsc_pkg.sv ----
// shared constants and types for the queue status and command block
package aqsc_pkg;
    // register byte addresses
    localparam logic [8:0] CTRL1_OFFS = 9'h000;
    localparam logic [8:0] CTRL2_OFFS = 9'h004;
    localparam logic [8:0] STATUS_OFFS = 9'h008;
    localparam logic [8:0] TABLE_OFFS = 9'h100;
    localparam int TABLE_DEPTH = 40;
    localparam logic [5:0] LAST_ENTRY = 6'h27;
    localparam logic [5:0] END_MARK = 6'h3F;
    // status word fields: six sticky flags from bit 10 upward
    localparam int FLAG_LSB = 10;
    localparam int F_Q2_TRIGGER_OVERFLOW = 0;
    localparam int F_Q1_TRIGGER_OVERFLOW = 1;
    localparam int F_PF2 = 2;
    localparam int F_CF2 = 3;
    localparam int F_PF1 = 4;
    localparam int F_CF1 = 5;
    localparam int QS_LSB = 6;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    // control word fields
    localparam int SSE_BIT = 13;
    localparam int Q2_DONE_IRQ_ENABLE_BIT = 15;
    localparam int MODE_LSB = 8;
    localparam int RES_BIT = 7;
    localparam logic [5:0] BQ2_RESET = 6'h27;
    // command entry fields
    localparam int PAUSE_BIT = 9;
    localparam int SKIP_BIT = 8;
    localparam int WIN_LSB = 6;
    // per-queue state codes
    localparam logic [1:0] QC_IDLE = 2'h0;
    localparam logic [1:0] QC_PAUSED = 2'h1;
    localparam logic [1:0] QC_ACTIVE = 2'h2;
    localparam logic [1:0] QC_PENDING = 2'h3;
    // converter timing, in clocks and converter ticks
    localparam int TICK_DIV = 4;
    localparam logic [5:0] CONV_TICKS = 6'h0A;
    localparam logic [5:0] SKIP_TICKS = 6'h08;
    localparam int TIMER_W = 18;
    // sequencer states
    typedef enum logic [2:0] {
        AQSC_IDLE = 3'b001,
        AQSC_FETCH = 3'b010,
        AQSC_CONV = 3'b100
    } aqsc_eng_type;
endpackage : aqsc_pkg

// ---- rtl/aqsc_axil.sv ----
// axi4-lite slave front end turning bus beats into register strobes
`timescale 1ns/1ps
module aqsc_axil
    import aqsc_pkg::*;
#(
    parameter int ADDR_W = 9
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write channels
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read channels
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // register side
    output logic wr_req,
    output logic [ADDR_W-1:0] wr_addr,
    output logic [15:0] wr_data,
    output logic [1:0] wr_strb,
    input wire logic wr_ok,
    output logic rd_req,
    output logic [ADDR_W-1:0] rd_addr,
    input wire logic [15:0] rd_data,
    input wire logic rd_ok
);
    // write: both channels are taken together, so arrival order is free
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            wr_req <= 1'b0;
            wr_addr <= '0;
            wr_data <= 16'h0000;
            wr_strb <= 2'h0;
        end else begin
            wr_req <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                !s_axi_bvalid && !wr_req) begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
                wr_req <= 1'b1;
                wr_addr <= s_axi_awaddr;
                wr_data <= s_axi_wdata[15:0];
                wr_strb <= s_axi_wstrb[1:0];
            end
        end
    end

    // write response, slverr for an unmapped word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else if (wr_req) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read address and data; upper half always reads zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            rd_req <= 1'b0;
            rd_addr <= '0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else begin
            rd_req <= 1'b0;
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid &&
                !rd_req) begin
                s_axi_arready <= 1'b1;
                rd_req <= 1'b1;
                rd_addr <= s_axi_araddr;
            end
            if (rd_req) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {16'h0000, rd_ok ? rd_data : 16'h0000};
                s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : aqsc_axil

// ---- rtl/aqsc_conv.sv ----
// converter tick divider and per-entry sample/convert timer
`timescale 1ns/1ps
module aqsc_conv
    import aqsc_pkg::*;
#(
    parameter int DIV = TICK_DIV
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control from the sequencer
    input wire logic start,
    input wire logic abort,
    input wire logic amp_skip,
    input wire logic [1:0] sample_window_sel,
    // timing outputs
    output logic converter_tick,
    output logic done
);
    logic [7:0] div_cnt;
    logic [5:0] remain;
    logic busy;

    // free-running converter tick, one clock wide
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt <= 8'h00;
            converter_tick <= 1'b0;
        end else if (div_cnt == 8'(DIV - 1)) begin
            div_cnt <= 8'h00;
            converter_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 8'h01;
            converter_tick <= 1'b0;
        end
    end

    // window of 2,4,8,16 ticks plus convert time; bypass shortens it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            remain <= 6'h00;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                busy <= 1'b0;
            end else if (start) begin
                remain <= (6'h02 << sample_window_sel) +
                          (amp_skip ? SKIP_TICKS : CONV_TICKS);
                busy <= 1'b1;
            end else if (busy && converter_tick) begin
                remain <= remain - 6'h01;
                if (remain == 6'h01) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule : aqsc_conv

// ---- rtl/aqsc_top.sv ----
// two-queue scan sequencer with status word and command table
//
// Summary of operation
// - resume choice latched at queue end or mode change
// - resumed queue 2 restarts subqueue or aborted entry
// - begin index starts queue 2, ends queue 1
// - queue 1 completion flag after last conversion
// - queue 2 completion flag after last conversion
// - queue 1 pause flag after paused entry converts
// - queue 2 pause flag after paused entry converts
// - queue 1 overrun only in external modes
// - queue 2 overrun in external or timer modes
// - read-only four-bit joint queue state
// - state codes idle, paused, active, pending
// - read-only pointer to current entry
// - pause entry halts queue, trigger resumes next
// - bypass bit alters timing of that entry
// - window field gives 2,4,8,16 ticks
// - input select 63 marks end of queue
// - queue 2 completion interrupt when enabled
`timescale 1ns/1ps
module aqsc_top
    import aqsc_pkg::*;
#(
    parameter int ADDR_W = 9,
    parameter int DEPTH = TABLE_DEPTH
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite register port
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // trigger pins
    input wire logic ext_trigger_a,
    input wire logic ext_trigger_b,
    // converter side and interrupt
    output logic [5:0] conv_channel,
    output logic conv_busy,
    output logic q2_done_irq
);
    logic wr_req, rd_req, wr_ok, rd_ok;
    logic [ADDR_W-1:0] wr_addr, rd_addr;
    logic [15:0] wr_data, rd_data, wdat, tab_wr;
    logic [1:0] wr_strb;
    logic [2:0] q1_operating_sel;
    logic [4:0] q2_operating_sel;
    logic sse1, sse2, q2_done_irq_enable, continuation_select, res_eff;
    logic [5:0] queue2_begin_index, command_pointer, ptr, q1_ptr, q2_ptr;
    logic [5:0] q2_sub;
    logic [9:0] cmd_tab [0:DEPTH-1];
    logic [9:0] entry;
    logic [5:0] flag, arm, flag_set;
    logic [1:0] q1st, q2st;
    logic owner, trig_a_q, trig_b_q, edge_a, edge_b;
    logic trig1, trig2, ext1_evt, ext2_evt, tmr_evt, sw1_go, sw2_go;
    logic wr_c1, wr_c2, wr_st, rd_st, mode2_chg;
    logic conv_start, conv_abort, conv_done, tick;
    logic is_end, fin, pause_evt, preempt;
    logic [TIMER_W-1:0] tmr_cnt, tmr_mask;
    aqsc_eng_type eng, next_eng;

    // byte-lane merge for the 16-bit registers
    function automatic logic [15:0] merge(input logic [15:0] old,
            input logic [15:0] nw, input logic [1:0] st);
        merge = {st[1] ? nw[15:8] : old[15:8], st[0] ? nw[7:0] : old[7:0]};
    endfunction : merge

    // table entry word decode, used for both reads and writes
    function automatic logic tab_hit(input logic [ADDR_W-1:0] a);
        tab_hit = a[8] && a[1:0] == 2'h0 && a[7:2] <= LAST_ENTRY;
    endfunction : tab_hit

    aqsc_axil #(.ADDR_W(ADDR_W)) u_bus (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data),
        .wr_strb(wr_strb), .wr_ok(wr_ok), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_ok(rd_ok)
    );

    aqsc_conv u_conv (
        .aclk(aclk), .aresetn(aresetn), .start(conv_start),
        .abort(conv_abort), .amp_skip(entry[SKIP_BIT]),
        .sample_window_sel(entry[WIN_LSB +: 2]),
        .converter_tick(tick), .done(conv_done)
    );

    // address decode
    assign wr_c1 = wr_req && wr_addr == CTRL1_OFFS;
    assign wr_c2 = wr_req && wr_addr == CTRL2_OFFS;
    assign wr_st = wr_req && wr_addr == STATUS_OFFS;
    assign rd_st = rd_req && rd_addr == STATUS_OFFS;
    assign wr_ok = wr_c1 || wr_c2 || wr_st || tab_hit(wr_addr);
    assign rd_ok = rd_addr == CTRL1_OFFS || rd_addr == CTRL2_OFFS ||
                   rd_addr == STATUS_OFFS || tab_hit(rd_addr);
    assign wdat = merge(16'h0000, wr_data, wr_strb);
    assign tab_wr = merge({6'h00, cmd_tab[wr_addr[7:2]]}, wr_data, wr_strb);
    assign mode2_chg = wr_c2 && wr_strb[1] &&
                       wr_data[MODE_LSB +: 5] != q2_operating_sel;

    // read mux; single-scan enables always read zero
    always_comb begin
        rd_data = 16'h0000;
        if (rd_addr == CTRL1_OFFS)
            rd_data = {5'h00, q1_operating_sel, 8'h00};
        else if (rd_addr == CTRL2_OFFS)
            rd_data = {q2_done_irq_enable, 2'h0, q2_operating_sel,
                       continuation_select, 1'b0, queue2_begin_index};
        else if (rd_addr == STATUS_OFFS)
            rd_data = {flag[F_CF1], flag[F_PF1], flag[F_CF2], flag[F_PF2],
                       flag[F_Q1_TRIGGER_OVERFLOW], flag[F_Q2_TRIGGER_OVERFLOW], q1st, q2st,
                       command_pointer};
        else if (tab_hit(rd_addr))
            rd_data = {6'h00, cmd_tab[rd_addr[7:2]]};
    end

    // control registers; the pointer has no write path at all
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q1_operating_sel <= 3'h0;
            q2_operating_sel <= 5'h00;
            q2_done_irq_enable <= 1'b0;
            continuation_select <= 1'b0;
            queue2_begin_index <= BQ2_RESET;
        end else begin
            if (wr_c1 && wr_strb[1])
                q1_operating_sel <= wr_data[MODE_LSB +: 3];
            if (wr_c2 && wr_strb[1]) begin
                q2_operating_sel <= wr_data[MODE_LSB +: 5];
                q2_done_irq_enable <= wr_data[Q2_DONE_IRQ_ENABLE_BIT];
            end
            if (wr_c2 && wr_strb[0]) begin
                continuation_select <= wr_data[RES_BIT];
                queue2_begin_index <= wr_data[5:0];
            end
        end
    end

    // command table; no reset, contents are undefined until written
    always_ff @(posedge aclk) begin
        if (tab_hit(wr_addr) && wr_req)
            cmd_tab[wr_addr[7:2]] <= tab_wr[9:0];
    end

    // pin edges, and the interval timer counted in converter ticks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_a_q <= ext_trigger_a; // no false edge right after reset
            trig_b_q <= ext_trigger_b;
            tmr_cnt <= '0;
        end else begin
            trig_a_q <= ext_trigger_a;
            trig_b_q <= ext_trigger_b;
            if (mode2_chg)
                tmr_cnt <= '0;
            else if (tick)
                tmr_cnt <= tmr_cnt + 1'b1;
        end
    end
    assign edge_a = q1_operating_sel[0] ? (trig_a_q && !ext_trigger_a)
                                        : (!trig_a_q && ext_trigger_a);
    assign edge_b = q2_operating_sel[0] ? (trig_b_q && !ext_trigger_b)
                                        : (!trig_b_q && ext_trigger_b);
    assign tmr_mask = (TIMER_W'(1) << (5'(q2_operating_sel[3:0]) + 5'h03))
                      - TIMER_W'(1);
    assign ext1_evt = q1_operating_sel[1] && edge_a;
    assign ext2_evt = q2_operating_sel[3:1] == 3'h1 && edge_b;
    assign tmr_evt = q2_operating_sel[3:0] >= 4'h4 &&
                     q2_operating_sel[3:0] <= 4'hE && tick &&
                     (tmr_cnt & tmr_mask) == tmr_mask;
    // software start is a pulse, so a paused queue waits for a new write
    assign trig1 = (ext1_evt && (q1_operating_sel[2] || sse1)) ||
                   (q1_operating_sel[1:0] == 2'h1 && sw1_go &&
                    q1st != QC_ACTIVE);
    assign trig2 = ((ext2_evt || tmr_evt) &&
                    (q2_operating_sel[4] || sse2)) ||
                   (q2_operating_sel[3:0] == 4'h1 && sw2_go &&
                    q2st != QC_ACTIVE);

    // single-scan enables, dropped when the scan completes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sse1 <= 1'b0;
            sse2 <= 1'b0;
            sw1_go <= 1'b0;
            sw2_go <= 1'b0;
        end else begin
            // one clock after the write, when the new mode is in place
            sw1_go <= wr_c1 && wr_strb[1] && wr_data[SSE_BIT];
            sw2_go <= wr_c2 && wr_strb[1] && wr_data[SSE_BIT];
            if (wr_c1 && wr_strb[1])
                sse1 <= wr_data[SSE_BIT];
            else if (fin && !owner)
                sse1 <= 1'b0;
            if (wr_c2 && wr_strb[1])
                sse2 <= wr_data[SSE_BIT];
            else if (fin && owner)
                sse2 <= 1'b0;
        end
    end

    // sequencer decode of the fetched entry
    assign entry = cmd_tab[ptr];
    assign is_end = ptr > LAST_ENTRY || entry[5:0] == END_MARK ||
                    (!owner && ptr == queue2_begin_index);
    assign preempt = eng != AQSC_IDLE &&
                     ((owner && q1st == QC_ACTIVE) ||
                      (!owner && q1st != QC_ACTIVE) ||
                      (owner && q2st != QC_ACTIVE) || (owner && mode2_chg));
    assign fin = eng == AQSC_FETCH && !preempt && is_end;
    assign conv_start = eng == AQSC_FETCH && !preempt && !is_end;
    assign conv_abort = preempt;
    assign pause_evt = eng == AQSC_CONV && !preempt && conv_done &&
                       entry[PAUSE_BIT];

    // next sequencer state
    always_comb begin
        next_eng = eng;
        case (eng)
            AQSC_IDLE:
                if (q1st == QC_ACTIVE || q2st == QC_ACTIVE)
                    next_eng = AQSC_FETCH;
            AQSC_FETCH:
                next_eng = (preempt || is_end) ? AQSC_IDLE : AQSC_CONV;
            AQSC_CONV:
                if (preempt || pause_evt)
                    next_eng = AQSC_IDLE;
                else if (conv_done)
                    next_eng = AQSC_FETCH;
            default:
                next_eng = AQSC_IDLE;
        endcase
    end

    // sequencer registers and per-queue resume pointers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eng <= AQSC_IDLE;
            owner <= 1'b0;
            ptr <= 6'h00;
            q1_ptr <= 6'h00;
            q2_ptr <= BQ2_RESET;
            q2_sub <= BQ2_RESET;
            command_pointer <= 6'h00;
            res_eff <= 1'b0;
            conv_channel <= 6'h00;
            conv_busy <= 1'b0;
        end else begin
            eng <= next_eng;
            conv_busy <= next_eng == AQSC_CONV;
            if (eng == AQSC_IDLE) begin
                // queue 1 wins; queue 2 only runs when queue 1 is not active
                owner <= q1st != QC_ACTIVE;
                ptr <= (q1st == QC_ACTIVE) ? q1_ptr : q2_ptr;
            end
            if (conv_start) begin
                command_pointer <= ptr;
                conv_channel <= entry[5:0];
            end
            if (conv_done && eng == AQSC_CONV && !preempt)
                ptr <= ptr + 6'h01;
            if (owner && preempt && q1st == QC_ACTIVE)
                q2_ptr <= res_eff ? ptr : q2_sub;
            else if (owner && pause_evt) begin
                q2_ptr <= ptr + 6'h01;
                q2_sub <= ptr + 6'h01;
            end else if ((owner && fin) || mode2_chg ||
                         (q2st == QC_IDLE && eng == AQSC_IDLE)) begin
                q2_ptr <= queue2_begin_index;
                q2_sub <= queue2_begin_index;
            end
            if (!owner && pause_evt)
                q1_ptr <= ptr + 6'h01;
            else if ((!owner && fin) || q1st == QC_IDLE)
                q1_ptr <= 6'h00;
            // the resume choice is sampled only at these two points
            if ((owner && fin) || mode2_chg)
                res_eff <= continuation_select;
        end
    end

    // queue 1 state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q1st <= QC_IDLE;
        end else if (wr_c1 && wr_strb[1] &&
                     wr_data[MODE_LSB +: 3] != q1_operating_sel) begin
            q1st <= QC_IDLE;
        end else if (!owner && pause_evt) begin
            q1st <= QC_PAUSED;
        end else if (!owner && fin) begin
            q1st <= (q1_operating_sel == 3'h5) ? QC_ACTIVE : QC_IDLE;
        end else if (trig1 && q1st != QC_ACTIVE) begin
            q1st <= QC_ACTIVE;
        end
    end

    // queue 2 state; a trigger while queue 1 runs gives pending, an active queue 2 preempted by queue 1 stays active
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q2st <= QC_IDLE;
        end else if (mode2_chg) begin
            q2st <= QC_IDLE;
        end else if (owner && pause_evt) begin
            q2st <= QC_PAUSED;
        end else if (owner && fin) begin
            q2st <= (q2_operating_sel == 5'h11) ? QC_ACTIVE : QC_IDLE;
        end else if (trig2 && (q2st == QC_IDLE || q2st == QC_PAUSED)) begin
            q2st <= (q1st == QC_ACTIVE) ? QC_PENDING : QC_ACTIVE;
        end else if (q2st == QC_PENDING && q1st != QC_ACTIVE) begin
            q2st <= QC_ACTIVE;
        end
    end

    // hardware events that set the sticky flags
    always_comb begin
        flag_set = 6'h00;
        flag_set[F_CF1] = !owner && fin;
        flag_set[F_PF1] = !owner && pause_evt;
        flag_set[F_CF2] = owner && fin;
        flag_set[F_PF2] = owner && pause_evt;
        flag_set[F_Q1_TRIGGER_OVERFLOW] = ext1_evt && q1st == QC_ACTIVE;
        flag_set[F_Q2_TRIGGER_OVERFLOW] = (ext2_evt || tmr_evt) &&
                           (q2st == QC_ACTIVE || q2st == QC_PENDING);
    end

    // sticky flags: read as one arms the clear, a new event beats it
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_flag
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    flag[gi] <= STATUS_RESET[FLAG_LSB + gi];
                    arm[gi] <= 1'b0;
                end else begin
                    if (flag_set[gi])
                        flag[gi] <= 1'b1;
                    else if (wr_st && arm[gi] && !wdat[FLAG_LSB + gi] &&
                             wr_strb[1])
                        flag[gi] <= 1'b0;
                    if (rd_st && flag[gi])
                        arm[gi] <= 1'b1;
                    else if (wr_st)
                        arm[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // completion interrupt request follows the flag while enabled
    always_ff @(posedge aclk) begin
        if (!aresetn)
            q2_done_irq <= 1'b0;
        else
            q2_done_irq <= q2_done_irq_enable && flag[F_CF2];
    end
endmodule : aqsc_top

// ---- dv/aqsc_assertions.sv ----
// checker for bus handshakes and converter timing
`timescale 1ns/1ps
module aqsc_checker (
    // clock, reset and watched outputs
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic conv_busy
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready wider than one cycle");
    w_pair_a: assert property (s_axi_awready == s_axi_wready)
        else $error("awready and wready apart");
    b_after_a: assert property (s_axi_awready |=> s_axi_bvalid)
        else $error("no write response after accept");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    r_after_a: assert property (s_axi_arready |=> s_axi_rvalid)
        else $error("no read data after accept");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
    hi_zero_a: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    busy_min_a: assert property ($rose(conv_busy) |-> conv_busy[*8])
        else $error("conversion shorter than sample window");
endmodule : aqsc_checker
bind aqsc_top aqsc_checker i_aqsc_checker (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .conv_busy(conv_busy));

// ---- dv/aqsc_top_test.sv ----
// register-level test of the queue status and command block
`timescale 1ns/1ps
module aqsc_top_test;
    import aqsc_pkg::*;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic awr, wr, bv, arr, rv, ta = 0, tb = 0, busy, irq;
    logic [8:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd, v;
    logic [1:0] br, rr;
    logic [5:0] ch;
    int fails = 0, n_tests = 0;
    aqsc_top i_aqsc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rre), .ext_trigger_a(ta), .ext_trigger_b(tb),
        .conv_channel(ch), .conv_busy(busy), .q2_done_irq(irq));
    initial forever #4 aclk = ~aclk;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // write both channels at once, wait for the response
    task wr_reg(input logic [8:0] a, input logic [15:0] d);
        @(posedge aclk);
        awa <= a; wd <= {16'h0000, d}; awv <= 1; wv <= 1; bre <= 1;
        do @(posedge aclk); while (awr !== 1'b1);
        awv <= 0; wv <= 0;
        while (bv !== 1'b1) @(posedge aclk);
        bre <= 0;
    endtask : wr_reg
    task rd_reg(input logic [8:0] a);
        @(posedge aclk);
        ara <= a; arv <= 1; rre <= 1;
        do @(posedge aclk); while (arr !== 1'b1);
        arv <= 0;
        while (rv !== 1'b1) @(posedge aclk);
        v = {rd[31:2], rd[1:0]};
        rre <= 0;
    endtask : rd_reg
    task give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    // watchdog: the run needs well under 3000 cycles
    initial begin
        #60000;
        fails++;
        give_verdict;
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        rd_reg(STATUS_OFFS); chk(v, 32'h00000000);
        rd_reg(CTRL2_OFFS); chk(v, 32'h00000027);
        rd_reg(9'h0FC); chk({v[31:2], rr}, 32'h00000002);
        // pause entry, bypass entry, then end marker
        wr_reg(TABLE_OFFS, 16'h0245);
        wr_reg(TABLE_OFFS + 9'h004, 16'h0186);
        wr_reg(TABLE_OFFS + 9'h008, 16'h003F);
        rd_reg(TABLE_OFFS); chk(v, 32'h00000245);
        wr_reg(CTRL1_OFFS, 16'h2100);
        repeat (400) @(posedge aclk);
        rd_reg(STATUS_OFFS); chk(v, 32'h00004100);
        chk({26'h0, ch}, 32'h00000005);
        wr_reg(CTRL1_OFFS, 16'h2100);
        repeat (400) @(posedge aclk);
        rd_reg(STATUS_OFFS); chk(v, 32'h0000C001);
        chk({26'h0, ch}, 32'h00000006);
        wr_reg(STATUS_OFFS, 16'hFFFF);
        rd_reg(STATUS_OFFS); chk(v, 32'h0000C001);
        wr_reg(STATUS_OFFS, 16'h0000);
        rd_reg(STATUS_OFFS); chk(v, 32'h00000001);
        // queue 2 single scan from entry 1, completion request enabled
        wr_reg(CTRL2_OFFS, 16'hA101);
        repeat (200) @(posedge aclk);
        chk({31'h0, irq}, 32'h00000001);
        rd_reg(STATUS_OFFS); chk(v, 32'h00002001);
        rd_reg(CTRL2_OFFS); chk(v, 32'h00008101);
        give_verdict;
    end
endmodule : aqsc_top_test
